// ==== design/fsq_top.sv ====
// Flash sequencer: erase/program commands, page latch, checksum engine, power-up calibration
`timescale 1ns/1ns
module fsq_top
  import fsq_pkg::*;
#(
  parameter logic [31:0] CAL_ADDR = 32'h00000000
)
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PORESETN,
  input wire logic [8:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output fsq_flash_req_s FL_REQ,
  input wire fsq_flash_rsp_s FL_RSP,
  output logic FETCH_HOLD,
  output logic CRC_IRQ,
  output logic [31:0] CAL_DATA
);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic d);
    return {c[14:0], 1'b0} ^ ((c[15] ^ d) ? FSQ_CRC_POLY : 16'h0000);
  endfunction : crc_bit

  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    // Least significant bit enters first
    for (int i = 0; i < 32; i++)
    begin
      r = crc_bit(r, d[i]);
    end
    return r;
  endfunction : crc_word

  fsq_state_e state_q;
  logic [3:0] rd_cnt_q;
  logic [3:0] gap_cnt_q;
  logic [5:0] idx_q;
  logic [5:0] widx_q;
  logic ph_q;
  logic [15:0] word_cnt_q;
  logic [15:0] crc_acc_q;
  logic [31:0] rd_addr_q;
  logic [31:0] wdata_q;
  logic latch_we_q;
  logic op_start_q;
  fsq_op_e op_q;
  logic info_q;
  logic [31:0] addr_q;
  logic [15:0] result_q;
  logic [31:0] cal_q;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  logic [9:0] len_q;
  logic [3:0] period_q;
  logic ie_q;
  logic slow_q;
  logic pause_q;
  logic done_q;
  logic run_q;
  logic refused_q;

  logic op_busy;
  logic sel_ctrl, sel_cmd, sel_addr, sel_buf;
  logic wr_ctrl, wr_cmd, wr_buf;
  logic cmd_go, crc_go, crc_fin, rd_last;
  logic cmd_refused;
  logic [3:0] rd_limit;
  logic [15:0] total_words;
  logic [31:0] ctrl_rd;
  logic [31:0] ctrl_wr;
  logic [31:0] latch_rdata;
  logic [2:0] cmd_op;

  assign op_busy = (state_q == FSQ_ST_LOAD) || (state_q == FSQ_ST_OP_WAIT);
  assign FETCH_HOLD = op_busy;

  assign sel_ctrl = (AVS_ADDRESS == FSQ_CRC_CTRL_OFS);
  assign sel_cmd = (AVS_ADDRESS == FSQ_CMD_OFS);
  assign sel_addr = (AVS_ADDRESS == FSQ_ADDR_OFS);
  assign sel_buf = AVS_ADDRESS[8];
  assign wr_ctrl = AVS_WRITE && sel_ctrl && !op_busy;
  assign wr_cmd = AVS_WRITE && sel_cmd && AVS_BYTEENABLE[0];
  assign wr_buf = AVS_WRITE && sel_buf && !op_busy;
  assign ctrl_wr = be_merge(ctrl_rd, AVS_WRITEDATA, AVS_BYTEENABLE);
  assign cmd_op = AVS_WRITEDATA[2:0];

  // Block and chip erase do not exist on the information block
  assign cmd_refused = AVS_WRITEDATA[FSQ_CMD_INFO_BIT] &&
                       ((cmd_op == FSQ_OP_BLOCK_ERASE) || (cmd_op == FSQ_OP_CHIP_ERASE));
  assign cmd_go = wr_cmd && (state_q == FSQ_ST_IDLE) && !cmd_refused && (cmd_op != FSQ_OP_NONE) &&
                  (cmd_op <= FSQ_OP_PAGE_PROG);
  assign crc_go = wr_ctrl && ctrl_wr[FSQ_START_BIT] && (state_q == FSQ_ST_IDLE) && !cmd_go;

  assign ctrl_rd = {6'h00, len_q, period_q, 3'h0, ie_q, 4'h0, slow_q, pause_q, done_q, run_q};
  assign total_words = 16'((32'(len_q) + 32'd1) * FSQ_PAGE_WORDS);
  assign rd_limit = (state_q == FSQ_ST_CAL) ? FSQ_PERIOD_MAX : period_q;
  assign rd_last = (rd_cnt_q == rd_limit);
  assign crc_fin = (state_q == FSQ_ST_CRC_RD) && !pause_q && rd_last && (word_cnt_q == total_words - 16'd1);

  assign CRC_IRQ = done_q && ie_q;
  assign CAL_DATA = cal_q;

  assign FL_REQ.rd = (state_q == FSQ_ST_CAL) || ((state_q == FSQ_ST_CRC_RD) && !pause_q);
  assign FL_REQ.op_start = op_start_q;
  assign FL_REQ.op = op_q;
  assign FL_REQ.info = info_q;
  assign FL_REQ.latch_we = latch_we_q;
  assign FL_REQ.latch_idx = widx_q;
  assign FL_REQ.addr = (state_q == FSQ_ST_CAL) ? CAL_ADDR : ((state_q == FSQ_ST_CRC_RD) ? rd_addr_q : addr_q);
  assign FL_REQ.wdata = wdata_q;

  // Reads wait one cycle so read data come from a register
  assign AVS_WAITREQUEST = AVS_READ && !rd_ack_q;
  assign AVS_READDATA = rdata_q;

  fsq_latch_mem u_latch
  (
    .CLK(CLK),
    .WE(wr_buf),
    .BE(AVS_BYTEENABLE),
    .WADDR(AVS_ADDRESS[7:2]),
    .WDATA(AVS_WRITEDATA),
    .RADDR(idx_q),
    .RDATA(latch_rdata)
  );

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      rd_ack_q <= AVS_READ && !rd_ack_q;
      if (AVS_READ && !rd_ack_q)
      begin
        case (AVS_ADDRESS)
          FSQ_CRC_CTRL_OFS: rdata_q <= ctrl_rd;
          FSQ_CMD_OFS: rdata_q <= {28'h0000000, info_q, op_q};
          FSQ_STATUS_OFS: rdata_q <= {29'h00000000, refused_q, (state_q != FSQ_ST_CAL), op_busy};
          FSQ_ADDR_OFS: rdata_q <= addr_q;
          FSQ_CAL_OFS: rdata_q <= cal_q;
          FSQ_RESULT_OFS: rdata_q <= {16'h0000, result_q};
          default: rdata_q <= 32'h00000000; // Latch words are write-only
        endcase
      end
    end
  end

  // Only power-on reset clears these, system reset leaves them alone
  always_ff @(posedge CLK or negedge PORESETN)
  begin
    if (!PORESETN)
    begin
      addr_q <= FSQ_ADDR_RST;
      result_q <= FSQ_RESULT_RST;
    end
    else
    begin
      if (AVS_WRITE && sel_addr)
      begin
        addr_q <= be_merge(addr_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (crc_fin)
      begin
        result_q <= crc_word(crc_acc_q, FL_RSP.rdata);
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      len_q <= FSQ_CRC_CTRL_RST[25:16];
      period_q <= FSQ_CRC_CTRL_RST[15:12];
      ie_q <= FSQ_CRC_CTRL_RST[FSQ_IE_BIT];
      slow_q <= FSQ_CRC_CTRL_RST[FSQ_SLOW_BIT];
      pause_q <= FSQ_CRC_CTRL_RST[FSQ_PAUSE_BIT];
      done_q <= FSQ_CRC_CTRL_RST[FSQ_DONE_BIT];
      run_q <= FSQ_CRC_CTRL_RST[FSQ_START_BIT];
    end
    else
    begin
      if (wr_ctrl)
      begin
        len_q <= ctrl_wr[FSQ_LEN_LSB +: 10];
        period_q <= ctrl_wr[FSQ_PERIOD_LSB +: 4];
        ie_q <= ctrl_wr[FSQ_IE_BIT];
        slow_q <= ctrl_wr[FSQ_SLOW_BIT];
        pause_q <= ctrl_wr[FSQ_PAUSE_BIT];
        done_q <= ctrl_wr[FSQ_DONE_BIT];
      end
      if (crc_go)
      begin
        run_q <= 1'b1;
        done_q <= 1'b0;
      end
      // Completion beats a software clear in the same cycle
      if (crc_fin)
      begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      op_q <= FSQ_OP_NONE;
      info_q <= 1'b0;
      refused_q <= 1'b0;
    end
    else if (wr_cmd && (state_q == FSQ_ST_IDLE))
    begin
      refused_q <= cmd_refused;
      if (cmd_go)
      begin
        op_q <= fsq_op_e'(cmd_op);
        info_q <= AVS_WRITEDATA[FSQ_CMD_INFO_BIT];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_q <= FSQ_ST_CAL;
      rd_cnt_q <= 4'h0;
      gap_cnt_q <= 4'h0;
      idx_q <= 6'h00;
      widx_q <= 6'h00;
      ph_q <= 1'b0;
      word_cnt_q <= 16'h0000;
      crc_acc_q <= FSQ_CRC_SEED;
      rd_addr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      latch_we_q <= 1'b0;
      op_start_q <= 1'b0;
      cal_q <= 32'h00000000;
    end
    else
    begin
      latch_we_q <= 1'b0;
      op_start_q <= 1'b0;
      case (state_q)
        FSQ_ST_CAL:
        begin
          // Slowest read timing, the control register is not trusted yet
          rd_cnt_q <= rd_cnt_q + 4'h1;
          if (rd_last)
          begin
            cal_q <= FL_RSP.rdata;
            rd_cnt_q <= 4'h0;
            state_q <= FSQ_ST_IDLE;
          end
        end
        FSQ_ST_IDLE:
        begin
          if (cmd_go && (cmd_op == FSQ_OP_PAGE_PROG))
          begin
            idx_q <= 6'h00;
            ph_q <= 1'b0;
            state_q <= FSQ_ST_LOAD;
          end
          else if (cmd_go)
          begin
            op_start_q <= 1'b1;
            state_q <= FSQ_ST_OP_WAIT;
          end
          else if (crc_go)
          begin
            rd_addr_q <= addr_q;
            word_cnt_q <= 16'h0000;
            crc_acc_q <= FSQ_CRC_SEED;
            rd_cnt_q <= 4'h0;
            state_q <= FSQ_ST_CRC_RD;
          end
        end
        FSQ_ST_LOAD:
        begin
          // Phase 0 addresses the staging memory, phase 1 hands the word to the macro latch
          ph_q <= !ph_q;
          if (ph_q)
          begin
            // The index moves on at this edge, so the word keeps its own copy
            widx_q <= idx_q;
            wdata_q <= latch_rdata;
            latch_we_q <= 1'b1;
            if (idx_q == FSQ_LATCH_LAST)
            begin
              state_q <= FSQ_ST_OP_WAIT;
            end
            else
            begin
              idx_q <= idx_q + 6'h01;
            end
          end
        end
        FSQ_ST_OP_WAIT:
        begin
          // The program start follows the last latch word by one cycle
          if (latch_we_q && (op_q == FSQ_OP_PAGE_PROG))
          begin
            op_start_q <= 1'b1;
          end
          else if (FL_RSP.op_done && !op_start_q)
          begin
            state_q <= FSQ_ST_IDLE;
          end
        end
        FSQ_ST_CRC_RD:
        begin
          if (pause_q)
          begin
            rd_cnt_q <= 4'h0;
          end
          else if (rd_last)
          begin
            rd_cnt_q <= 4'h0;
            crc_acc_q <= crc_word(crc_acc_q, FL_RSP.rdata);
            word_cnt_q <= word_cnt_q + 16'h0001;
            rd_addr_q <= rd_addr_q + FSQ_WORD_STEP;
            gap_cnt_q <= 4'h0;
            if (crc_fin)
            begin
              state_q <= FSQ_ST_IDLE;
            end
            else if (slow_q)
            begin
              state_q <= FSQ_ST_CRC_GAP;
            end
          end
          else
          begin
            rd_cnt_q <= rd_cnt_q + 4'h1;
          end
        end
        FSQ_ST_CRC_GAP:
        begin
          if (!pause_q)
          begin
            gap_cnt_q <= gap_cnt_q + 4'h1;
            if (gap_cnt_q == FSQ_SLOW_GAP_LAST)
            begin
              state_q <= FSQ_ST_CRC_RD;
            end
          end
        end
        default:
        begin
          state_q <= FSQ_ST_IDLE;
        end
      endcase
    end
  end

  // Helper: length of each read strobe and number of words in a run
  logic [4:0] rd_len_q;
  logic [15:0] chk_words_q;
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rd_len_q <= 5'h00;
      chk_words_q <= 16'h0000;
    end
    else
    begin
      rd_len_q <= (FL_REQ.rd && !rd_last) ? rd_len_q + 5'h01 : 5'h00;
      if (crc_go)
      begin
        chk_words_q <= 16'h0000;
      end
      else if ((state_q == FSQ_ST_CRC_RD) && !pause_q && rd_last)
      begin
        chk_words_q <= chk_words_q + 16'h0001;
      end
    end
  end

  crc_poly_a: assert property (@(posedge CLK) disable iff (!RESETN)
    crc_bit(16'h0000, 1'b1) == 16'h8005 && crc_bit(16'h8000, 1'b0) == 16'h8005)
    else $error("checksum polynomial wrong");

  info_erase_a: assert property (@(posedge CLK) disable iff (!RESETN)
    wr_cmd && state_q == FSQ_ST_IDLE && cmd_refused |=> state_q == FSQ_ST_IDLE && !op_start_q)
    else $error("block or chip erase accepted on information block");

  fetch_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
    cmd_go |=> FETCH_HOLD until (state_q == FSQ_ST_IDLE))
    else $error("fetch not held during flash operation");

  irq_done_a: assert property (@(posedge CLK) disable iff (!RESETN)
    crc_fin && ie_q && !wr_ctrl |=> CRC_IRQ && done_q)
    else $error("completion interrupt missing");

  read_stretch_a: assert property (@(posedge CLK) disable iff (!RESETN)
    state_q == FSQ_ST_CRC_RD && !pause_q && rd_last |-> 5'(rd_len_q) == 5'(period_q))
    else $error("checksum read not stretched to period plus one");

  page_count_a: assert property (@(posedge CLK) disable iff (!RESETN)
    crc_fin |-> chk_words_q + 16'h0001 == total_words)
    else $error("checksum covered wrong number of words");

  slow_gap_a: assert property (@(posedge CLK) disable iff (!RESETN)
    state_q == FSQ_ST_CRC_RD && $past(state_q) == FSQ_ST_CRC_GAP |-> $past(gap_cnt_q) == FSQ_SLOW_GAP_LAST)
    else $error("slow step gap is not sixteen cycles");

  done_low_a: assert property (@(posedge CLK) disable iff (!RESETN)
    crc_go |=> !done_q && run_q)
    else $error("done flag not cleared at start");

  ctrl_locked_a: assert property (@(posedge CLK) disable iff (!RESETN)
    AVS_WRITE && sel_ctrl && op_busy |=> $stable(ctrl_rd))
    else $error("checksum control written while flash busy");

  latch_drop_a: assert property (@(posedge CLK) disable iff (!RESETN)
    AVS_WRITE && sel_buf && op_busy |-> !wr_buf)
    else $error("latch written while flash busy");

  result_load_a: assert property (@(posedge CLK) disable iff (!RESETN)
    crc_fin |=> result_q == crc_acc_q)
    else $error("checksum result not stored");

  prog_cov_c: cover property (@(posedge CLK) disable iff (!RESETN)
    state_q == FSQ_ST_LOAD ##[1:200] FL_REQ.op_start);
  crc_slow_c: cover property (@(posedge CLK) disable iff (!RESETN)
    state_q == FSQ_ST_CRC_GAP ##[1:40] crc_fin);
  erase_cov_c: cover property (@(posedge CLK) disable iff (!RESETN)
    cmd_go && cmd_op == FSQ_OP_BLOCK_ERASE);
  pause_cov_c: cover property (@(posedge CLK) disable iff (!RESETN)
    state_q == FSQ_ST_CRC_RD && pause_q ##1 !pause_q);

endmodule : fsq_top

// ==== shared/fsq_pkg.sv ====
// Shared constants and types for the flash sequencer with checksum engine
package fsq_pkg;

  localparam logic [8:0] FSQ_CRC_CTRL_OFS = 9'h004;
  localparam logic [8:0] FSQ_CMD_OFS = 9'h008;
  localparam logic [8:0] FSQ_STATUS_OFS = 9'h00C;
  localparam logic [8:0] FSQ_ADDR_OFS = 9'h010;
  localparam logic [8:0] FSQ_CAL_OFS = 9'h014;
  localparam logic [8:0] FSQ_RESULT_OFS = 9'h01C;
  localparam logic [8:0] FSQ_BUF_OFS = 9'h100;

  localparam logic [31:0] FSQ_CRC_CTRL_RST = 32'h0000F000;
  localparam logic [31:0] FSQ_ADDR_RST = 32'h00000000;
  localparam logic [15:0] FSQ_RESULT_RST = 16'h0000;
  localparam logic [15:0] FSQ_CRC_SEED = 16'h0000;
  localparam logic [15:0] FSQ_CRC_POLY = 16'h8005;

  localparam int FSQ_START_BIT = 0;
  localparam int FSQ_DONE_BIT = 1;
  localparam int FSQ_PAUSE_BIT = 2;
  localparam int FSQ_SLOW_BIT = 3;
  localparam int FSQ_IE_BIT = 8;
  localparam int FSQ_PERIOD_LSB = 12;
  localparam int FSQ_LEN_LSB = 16;
  localparam int FSQ_CMD_INFO_BIT = 3;

  localparam logic [3:0] FSQ_PERIOD_MAX = 4'hF;
  localparam logic [3:0] FSQ_SLOW_GAP_LAST = 4'hF;
  localparam logic [5:0] FSQ_LATCH_LAST = 6'h3F;
  localparam int FSQ_PAGE_WORDS = 64;
  localparam logic [31:0] FSQ_WORD_STEP = 32'h00000004;

  typedef enum logic [2:0]
  {
    FSQ_OP_NONE = 3'b000,
    FSQ_OP_PAGE_ERASE = 3'b001,
    FSQ_OP_BLOCK_ERASE = 3'b010,
    FSQ_OP_CHIP_ERASE = 3'b011,
    FSQ_OP_PAGE_PROG = 3'b100
  } fsq_op_e;

  typedef enum logic [2:0]
  {
    FSQ_ST_CAL = 3'b000,
    FSQ_ST_IDLE = 3'b001,
    FSQ_ST_LOAD = 3'b010,
    FSQ_ST_OP_WAIT = 3'b011,
    FSQ_ST_CRC_RD = 3'b100,
    FSQ_ST_CRC_GAP = 3'b101
  } fsq_state_e;

  typedef struct packed
  {
    logic rd;
    logic op_start;
    fsq_op_e op;
    logic info;
    logic latch_we;
    logic [5:0] latch_idx;
    logic [31:0] addr;
    logic [31:0] wdata;
  } fsq_flash_req_s;

  typedef struct packed
  {
    logic [31:0] rdata;
    logic op_done;
  } fsq_flash_rsp_s;

endpackage : fsq_pkg

// ==== design/fsq_latch_mem.sv ====
// Page write latch staging memory, 64 words, byte-lane writes, registered read
`timescale 1ns/1ns
module fsq_latch_mem
  import fsq_pkg::*;
(
  input wire logic CLK,
  input wire logic WE,
  input wire logic [3:0] BE,
  input wire logic [5:0] WADDR,
  input wire logic [31:0] WDATA,
  input wire logic [5:0] RADDR,
  output logic [31:0] RDATA
);

  logic [31:0] mem_q [0:FSQ_PAGE_WORDS-1];

  // No reset on the array: contents are undefined until software fills it
  always_ff @(posedge CLK)
  begin
    for (int b = 0; b < 4; b++)
    begin
      if (WE && BE[b])
      begin
        mem_q[WADDR][b*8 +: 8] <= WDATA[b*8 +: 8];
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    RDATA <= mem_q[RADDR];
  end

endmodule : fsq_latch_mem

// ==== verification/fsq_flash_model.sv ====
// Flash array model: patterned read data, timed erase/program, latch capture
`timescale 1ns/1ns
module fsq_flash_model
  import fsq_pkg::*;
#(
  parameter int OP_CYCLES = 20
)
(
  input wire logic CLK,
  input wire fsq_flash_req_s REQ,
  output fsq_flash_rsp_s RSP
);
  logic [31:0] page_q [64];
  logic [31:0] last_q = 32'h00000000;
  logic [31:0] rd_data;
  logic done_q = 1'b0;
  int busy_cnt = 0;
  fsq_op_e last_op_q = FSQ_OP_NONE;
  logic last_info_q = 1'b0;

  function automatic logic [31:0] word(input logic [31:0] a);
    return {a[15:0] ^ 16'hA5C3, ~a[15:0]};
  endfunction : word

  // Between reads the data lines toggle, so a sample taken the cycle after a read strobe ends never matches
  assign rd_data = REQ.rd ? word(REQ.addr) : ~last_q;
  assign RSP = {rd_data, done_q};

  always @(posedge CLK)
  begin
    last_q <= rd_data;
    if (REQ.latch_we)
      page_q[REQ.latch_idx] <= REQ.wdata;
    done_q <= (busy_cnt == 1);
    if (REQ.op_start)
    begin
      busy_cnt <= OP_CYCLES;
      last_op_q <= REQ.op;
      last_info_q <= REQ.info;
    end
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
  end
endmodule : fsq_flash_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the flash sequencer with checksum engine
`timescale 1ns/1ns
module tb_top;
  import fsq_pkg::*;
  localparam logic [31:0] CAL_A = 32'h00000040;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic PORESETN = 1'b0;
  logic [8:0] AVS_ADDRESS = 9'h000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  fsq_flash_req_s FL_REQ;
  fsq_flash_rsp_s FL_RSP;
  logic FETCH_HOLD;
  logic CRC_IRQ;
  logic [31:0] CAL_DATA;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int rd_hi = 0;
  int gap = 0;
  int gap_sum = 0;
  int snap;
  logic mon = 1'b0;
  logic [31:0] rv;
  logic [31:0] lw [64];
  logic [8:0] r_a [6] = '{9'h010, 9'h01C, 9'h100, 9'h040, 9'h004, 9'h004};
  logic [31:0] r_w [6] = '{32'h12345678, 32'hFFFFFFFF, 32'hDEADBEEF, 32'h00000005, 32'hFFFFFFFE, 32'h0000F000};
  logic [31:0] r_e [6] = '{32'h12345678, 32'h00000000, 32'h00000000, 32'h00000000, 32'h03FFF10E, 32'h0000F000};

  fsq_top #(.CAL_ADDR(CAL_A)) uut (.CLK, .RESETN, .PORESETN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .FL_REQ, .FL_RSP, .FETCH_HOLD,
    .CRC_IRQ, .CAL_DATA);
  fsq_flash_model fm (.CLK, .REQ(FL_REQ), .RSP(FL_RSP));

  always #50 CLK = ~CLK;

  // Sampled mid-cycle so the counts never race the design's own edge
  always @(negedge CLK)
  begin
    cyc++;
    if (mon && FL_REQ.rd)
    begin
      rd_hi++;
      gap_sum += gap;
      gap = 0;
    end
    else if (mon && rd_hi > 0)
      gap++;
    if (cyc == 20000)
    begin
      n_errors++;
      test_done;
    end
  end

  task automatic test_done;
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request stands until the rising edge that sees waitrequest low; read data are taken there
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= ~wr;
    do
    begin
      @(posedge CLK);
    end
    while (AVS_WAITREQUEST !== 1'b0);
    rv = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge CLK);
  endtask : bus

  task automatic poll(input logic [8:0] a, input int b, input logic v);
    int k;
    k = 0;
    do
    begin
      bus(1'b0, a, 32'h00000000);
      k++;
    end
    while (rv[b] !== v && k < 3000);
    chk(rv[b], v);
  endtask : poll

  task automatic hold(input logic lvl);
    int k;
    k = 0;
    do
    begin
      @(negedge CLK);
      k++;
    end
    while (FETCH_HOLD !== lvl && k < 500);
    chk(FETCH_HOLD, lvl);
    @(posedge CLK);
  endtask : hold

  function automatic logic [15:0] crc_exp(input logic [31:0] a, input int n);
    logic [15:0] c;
    logic [31:0] d;
    c = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      d = fm.word(a + 32'(4 * k));
      for (int i = 0; i < 32; i++)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction : crc_exp

  task automatic crc_start(input logic [31:0] a, input logic [31:0] ctl);
    bus(1'b1, FSQ_ADDR_OFS, a);
    rd_hi = 0;
    gap = 0;
    gap_sum = 0;
    mon = 1'b1;
    bus(1'b1, FSQ_CRC_CTRL_OFS, ctl | 32'h00000001);
    bus(1'b0, FSQ_CRC_CTRL_OFS, 32'h00000000);
    chk(rv[1:0], 2'b01);
  endtask : crc_start

  task automatic crc_end(input logic [31:0] a, input int words);
    poll(FSQ_CRC_CTRL_OFS, 1, 1'b1);
    mon = 1'b0;
    bus(1'b0, FSQ_RESULT_OFS, 32'h00000000);
    chk(rv, {16'h0000, crc_exp(a, words)});
  endtask : crc_end

  initial
  begin
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    PORESETN <= 1'b1;
    @(posedge CLK);
    bus(1'b0, FSQ_CRC_CTRL_OFS, 32'h00000000);
    chk(rv, 32'h0000F000);
    bus(1'b0, FSQ_ADDR_OFS, 32'h00000000);
    chk(rv, 32'h00000000);
    poll(FSQ_STATUS_OFS, 1, 1'b1);
    bus(1'b0, FSQ_CAL_OFS, 32'h00000000);
    chk(rv, fm.word(CAL_A));
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b1, r_a[i], r_w[i]);
      bus(1'b0, r_a[i], 32'h00000000);
      chk(rv, r_e[i]);
    end
    // One page, single-cycle reads, suspended part-way, interrupt enabled
    // At 10 MHz the fastest read setting already meets the flash read time
    crc_start(32'h00001000, 32'h00000100);
    bus(1'b1, FSQ_CRC_CTRL_OFS, 32'h00000105);
    snap = rd_hi;
    repeat (20) @(posedge CLK);
    chk(32'(rd_hi), 32'(snap));
    bus(1'b1, FSQ_CRC_CTRL_OFS, 32'h00000101);
    crc_end(32'h00001000, 64);
    @(negedge CLK);
    chk(CRC_IRQ, 1'b1);
    @(posedge CLK);
    // Three pages, three-cycle reads, slow stepping, interrupt disabled
    crc_start(32'h00002000, 32'h00022008);
    crc_end(32'h00002000, 192);
    chk(32'(rd_hi), 32'(192 * 3));
    chk(32'(gap_sum), 32'(191 * 16));
    chk(CRC_IRQ, 1'b0);
    for (int i = 0; i < 64; i++)
    begin
      lw[i] = {8'(i), 24'hC0FFEE};
      bus(1'b1, FSQ_BUF_OFS + 9'(4 * i), lw[i]);
    end
    bus(1'b1, FSQ_ADDR_OFS, 32'h00003000);
    for (int op = 1; op < 4; op++)
    begin
      bus(1'b1, FSQ_CMD_OFS, 32'(op));
      hold(1'b1);
      bus(1'b1, FSQ_CRC_CTRL_OFS, 32'h00000001);
      bus(1'b1, FSQ_BUF_OFS, 32'hBAD0BAD0);
      hold(1'b0);
      chk(32'(fm.last_op_q), 32'(op));
      bus(1'b0, FSQ_CRC_CTRL_OFS, 32'h00000000);
      chk(rv, 32'h0002200A);
    end
    bus(1'b1, FSQ_CMD_OFS, 32'h0000000A);
    bus(1'b0, FSQ_STATUS_OFS, 32'h00000000);
    chk(rv[2:0], 3'b110);
    bus(1'b1, FSQ_CMD_OFS, 32'h00000009);
    hold(1'b1);
    hold(1'b0);
    chk(fm.last_info_q, 1'b1);
    // The model's erase leaves page_q untouched, so only the words that programming writes are checked
    bus(1'b1, FSQ_CMD_OFS, 32'h00000004);
    hold(1'b1);
    hold(1'b0);
    for (int i = 0; i < 64; i++)
      chk(fm.page_q[i], lw[i]);
    bus(1'b1, FSQ_ADDR_OFS, 32'h0000ABC0);
    RESETN <= 1'b0;
    repeat (2) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    bus(1'b0, FSQ_ADDR_OFS, 32'h00000000);
    chk(rv, 32'h0000ABC0);
    bus(1'b0, FSQ_RESULT_OFS, 32'h00000000);
    chk(rv, {16'h0000, crc_exp(32'h00002000, 192)});
    bus(1'b0, FSQ_CRC_CTRL_OFS, 32'h00000000);
    chk(rv, 32'h0000F000);
    test_done;
  end
endmodule : tb_top
